//--- inc/lcd_cmd_pkg.sv
// constants and carrier types of the lcd command decoder
// assumes an apb master on pclk and 8-bit host bytes tagged by the type bit HB_TYPE_BIT
package lcd_cmd_pkg;
	// opcodes
	localparam logic [7:0] OP_DISPLAY_ON    = 8'hAF;
	localparam logic [7:0] OP_DISPLAY_OFF   = 8'hAE;
	localparam logic [7:0] OP_NORMAL_IMAGE  = 8'hA6;
	localparam logic [7:0] OP_INVERSE_IMAGE = 8'hA7;
	localparam logic [7:0] OP_COMMON_SCAN   = 8'hBB;
	localparam logic [7:0] OP_DISP_TIMING   = 8'hCA;
	localparam logic [7:0] OP_SLEEP_ENTER   = 8'h95;
	localparam logic [7:0] OP_SLEEP_EXIT    = 8'h94;
	localparam logic [7:0] OP_PAGE_WINDOW   = 8'h75;
	localparam logic [7:0] OP_COLUMN_WINDOW = 8'h15;
	localparam logic [7:0] OP_DATA_LAYOUT   = 8'hBC;
	localparam logic [7:0] OP_MEMORY_WRITE  = 8'h5C;
	localparam logic [7:0] OP_VOLUME_UP     = 8'hD6;
	localparam logic [7:0] OP_VOLUME_DOWN   = 8'hD7;

	// register byte addresses
	localparam logic [7:0] ADDR_HOST_BYTE = 8'h00;
	localparam logic [7:0] ADDR_STATUS    = 8'h04;
	localparam logic [7:0] ADDR_TIMING    = 8'h08;
	localparam logic [7:0] ADDR_WINDOW    = 8'h0C;
	localparam logic [7:0] ADDR_ADDRESS   = 8'h10;
	localparam logic [7:0] ADDR_LAYOUT    = 8'h14;

	// host byte register fields
	localparam int HB_TYPE_BIT = 8;

	// reset values
	localparam logic [1:0] RST_CLOCK_DIV   = 2'h0;
	localparam logic [1:0] RST_PATTERN     = 2'h0;
	localparam logic [5:0] RST_DUTY        = 6'h27;
	localparam logic [3:0] RST_INV_LINES   = 4'hA;
	localparam logic [2:0] RST_RGB_ORDER   = 3'h0;
	localparam logic [2:0] RST_GRAY_MODE   = 3'h2;
	localparam logic [2:0] RST_SCAN_ORDER  = 3'h0;
	localparam logic [5:0] RST_VOLUME      = 6'h20;
	localparam logic [7:0] RST_WIN_END     = 8'hFF;

	// limits
	localparam logic [5:0] VOLUME_MAX      = 6'h3F;
	localparam logic [5:0] VOLUME_MIN      = 6'h00;
	localparam logic [3:0] INV_LINES_MIN   = 4'h1;

	// line clock and pattern counts
	localparam logic [7:0] DIV_LOAD_2      = 8'h01;
	localparam logic [7:0] DIV_LOAD_4      = 8'h03;
	localparam logic [7:0] DIV_LOAD_8      = 8'h07;
	localparam logic [7:0] DIV_LOAD_1      = 8'h00;
	localparam logic [7:0] PAT_LINES_8     = 8'h07;
	localparam logic [7:0] PAT_LINES_4     = 8'h03;
	localparam logic [7:0] PAT_LINES_16    = 8'h0F;

	// decoder states
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_PARAM  = 4'b0010,
		ST_WRITE  = 4'b0100,
		ST_IGNORE = 4'b1000
	} dec_state_t;

	// timing settings
	typedef struct packed {
		logic [1:0] clock_div;
		logic [1:0] pattern;
		logic [5:0] duty;
		logic [3:0] inv_lines;
	} timing_t;

	// address window
	typedef struct packed {
		logic [7:0] page_start;
		logic [7:0] page_end;
		logic [7:0] col_start;
		logic [7:0] col_end;
	} window_t;

	// data layout settings
	typedef struct packed {
		logic       page_invert;
		logic       col_reverse;
		logic       page_dir;
		logic [2:0] rgb_order;
		logic [2:0] gray_mode;
	} layout_t;
endpackage

//--- rtl/window_counter.sv
// one axis of the ram address walk: counts start..end and wraps to start
// assumes start <= end is kept by the host
`timescale 1ns/1ps
module window_counter (
	input  wire logic       pclk,    // clock
	input  wire logic       presetn, // async reset, low
	input  wire logic       load,    // load start value
	input  wire logic       step,    // advance one position
	input  wire logic [7:0] start,   // window start
	input  wire logic [7:0] stop,    // window end
	output logic      [7:0] value,   // current address
	output logic            wrap     // at end, next step wraps
);
	logic [7:0] value_r;
	logic [7:0] value_nxt;

	// wrap when the end is reached so the other axis can carry
	assign wrap      = (value_r == stop);
	assign value_nxt = load ? start : (step ? (wrap ? start : value_r + 8'h01) : value_r);
	assign value     = value_r;

	// address register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_r <= 8'h00;
		end else begin
			value_r <= value_nxt;
		end
	end
endmodule // window_counter

//--- rtl/divider_tick.sv
// programmable tick generator: one pulse every (load+1) advance events while run is high
// assumes load changes only while the display is off
`timescale 1ns/1ps
module divider_tick (
	input  wire logic       pclk,    // clock
	input  wire logic       presetn, // async reset, low
	input  wire logic       run,     // counting enabled
	input  wire logic       advance, // count event
	input  wire logic [7:0] load,    // terminal count
	output logic            tick     // one-cycle pulse at terminal
);
	logic [7:0] count_r;
	logic [7:0] count_nxt;
	logic       at_end;

	assign at_end    = (count_r >= load);
	assign tick      = run && advance && at_end;
	assign count_nxt = !run ? 8'h00 : (advance ? (at_end ? 8'h00 : count_r + 8'h01) : count_r);

	// counter held at zero while stopped so a restart is aligned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= 8'h00;
		end else begin
			count_r <= count_nxt;
		end
	end
endmodule // divider_tick

//--- rtl/lcd_command_decoder.sv
// apb slave command decoder of a colour lcd driver
// assumes an apb master on pclk; host bytes are written to the host byte register
// Summary of operation
// [R1] type bit low is opcode, high is parameter
// [R2] display on drives outputs from data
// [R3] display on refused while sleeping
// [R4] display off forces mid level, blank low
// [R5] inverse flips image, normal restores it
// [R6] scan order: three bits, two halves
// [R7] host sets timing before sleep exit
// [R8] timing p1 high bits pick line divider
// [R9] timing p1 low bits pick pattern period
// [R10] timing p2 is duty lines/4 minus one
// [R11] timing p3 is inversion lines minus one
// [R12] sleep enter: sleep pin low, blank low
// [R13] sleep exit drives sleep pin high
// [R14] page window wraps page, steps column
// [R15] column window wraps column, steps page
// [R16] host gives window pairs, start below end
// [R17] layout p1: page invert, column reverse, direction
// [R18] layout p2 selects rgb placement
// [R19] volume opcodes step setting by one
// [R20] don't care parameter bits are ignored
// [R21] parameters counted; new opcode ends collection
// [R22] layout p3 selects gray depth
// [R23] rgb placement resets to zero
// [R24] memory write loads start, data advances
`timescale 1ns/1ps
module lcd_command_decoder (
	input  wire logic        pclk,            // 40 MHz clock
	input  wire logic        presetn,         // async reset, low
	input  wire logic        psel,            // apb select
	input  wire logic        penable,         // apb access phase
	input  wire logic        pwrite,          // apb direction
	input  wire logic [7:0]  paddr,           // apb byte address
	input  wire logic [31:0] pwdata,          // apb write data
	output logic      [31:0] prdata,          // apb read data
	output logic             pready,          // apb ready
	output logic             pslverr,         // apb error
	output logic             sleep_out_n,     // low while asleep
	output logic             panel_blank_n,   // low while blanked
	output logic             mid_drive_level, // outputs forced to mid level
	output logic             image_invert,    // shown image inverted
	output logic             supply_short,    // lcd supply tied to ground
	output logic             line_clock,      // line clock pulse
	output logic             drive_pattern_a, // drive pattern phase a
	output logic             drive_pattern_b, // drive pattern phase b
	output logic             frame_polarity,  // frame polarity
	output logic      [2:0]  scan_order,      // common scan order
	output logic      [5:0]  volume,          // electronic volume step
	output logic             ram_we,          // one-cycle ram write strobe
	output logic      [7:0]  ram_page,        // ram page address
	output logic      [7:0]  ram_col,         // ram column address
	output logic      [7:0]  ram_data         // ram write data
);
	lcd_cmd_pkg::dec_state_t state_r, state_nxt;
	lcd_cmd_pkg::timing_t    timing_r;
	lcd_cmd_pkg::window_t    window_r;
	lcd_cmd_pkg::layout_t    layout_r;
	logic [7:0]  opcode_r;
	logic [4:0]  pidx_r;
	logic [7:0]  pstash_r;
	logic        asleep_r;
	logic        disp_on_r;
	logic        invert_r;
	logic [2:0]  scan_r;
	logic [5:0]  volume_r;
	logic        we_r;
	logic [7:0]  data_r;
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic        cl_r, pa_r, pb_r, fr_r;

	// apb decode, each access answers one cycle into its access phase
	wire         access    = psel && penable && !pready_r;
	wire         wr_access = access && pwrite;
	wire         hit_host  = (paddr == lcd_cmd_pkg::ADDR_HOST_BYTE);
	wire         hit_stat  = (paddr == lcd_cmd_pkg::ADDR_STATUS);
	wire         hit_tim   = (paddr == lcd_cmd_pkg::ADDR_TIMING);
	wire         hit_win   = (paddr == lcd_cmd_pkg::ADDR_WINDOW);
	wire         hit_addr  = (paddr == lcd_cmd_pkg::ADDR_ADDRESS);
	wire         hit_lay   = (paddr == lcd_cmd_pkg::ADDR_LAYOUT);
	wire         mapped    = hit_host | hit_stat | hit_tim | hit_win | hit_addr | hit_lay;
	wire         host_wr   = wr_access && hit_host;
	wire         is_param  = pwdata[lcd_cmd_pkg::HB_TYPE_BIT];
	wire [7:0]   hbyte     = pwdata[7:0];
	wire         op_strobe = host_wr && !is_param; // [R1]
	wire         pm_strobe = host_wr && is_param;  // [R1]

	// parameter count of the opcode being taken, else of the one collecting;
	// unknown opcodes swallow their bytes
	wire [7:0] cnt_op    = op_strobe ? hbyte : opcode_r;
	wire [4:0] pcount =
		(cnt_op == lcd_cmd_pkg::OP_COMMON_SCAN)   ? 5'h01 :
		(cnt_op == lcd_cmd_pkg::OP_DISP_TIMING)   ? 5'h03 :
		(cnt_op == lcd_cmd_pkg::OP_PAGE_WINDOW)   ? 5'h02 :
		(cnt_op == lcd_cmd_pkg::OP_COLUMN_WINDOW) ? 5'h02 :
		(cnt_op == lcd_cmd_pkg::OP_DATA_LAYOUT)   ? 5'h03 : 5'h00;
	wire       in_param  = (state_r == lcd_cmd_pkg::ST_PARAM);
	wire       in_write  = (state_r == lcd_cmd_pkg::ST_WRITE);
	wire       take_par  = pm_strobe && in_param;                 // [R21]
	wire       last_par  = take_par && (pidx_r == pcount - 5'h01); // [R21]
	wire       wants_par = (pcount != 5'h00);
	wire       p0        = take_par && (pidx_r == 5'h00);
	wire       p1        = take_par && (pidx_r == 5'h01);
	wire       p2        = take_par && (pidx_r == 5'h02);
	wire       op_is_tim = (opcode_r == lcd_cmd_pkg::OP_DISP_TIMING);
	wire       op_is_pg  = (opcode_r == lcd_cmd_pkg::OP_PAGE_WINDOW);
	wire       op_is_cl  = (opcode_r == lcd_cmd_pkg::OP_COLUMN_WINDOW);
	wire       op_is_lay = (opcode_r == lcd_cmd_pkg::OP_DATA_LAYOUT);
	wire       op_is_scn = (opcode_r == lcd_cmd_pkg::OP_COMMON_SCAN);
	wire       op_mw     = op_strobe && (hbyte == lcd_cmd_pkg::OP_MEMORY_WRITE);

	// decoder state: new opcode always restarts collection
	always_comb begin
		state_nxt = state_r;
		if (op_strobe) begin // [R21]
			if (hbyte == lcd_cmd_pkg::OP_MEMORY_WRITE) begin
				state_nxt = lcd_cmd_pkg::ST_WRITE; // [R24]
			end else if (wants_par) begin
				state_nxt = lcd_cmd_pkg::ST_PARAM;
			end else begin
				state_nxt = lcd_cmd_pkg::ST_IGNORE;
			end
		end else if (last_par) begin
			state_nxt = lcd_cmd_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r  <= lcd_cmd_pkg::ST_IDLE;
			opcode_r <= 8'h00;
			pidx_r   <= 5'h00;
		end else begin
			state_r  <= state_nxt;
			opcode_r <= op_strobe ? hbyte : opcode_r;
			pidx_r   <= op_strobe ? 5'h00 : (take_par ? pidx_r + 5'h01 : pidx_r); // [R21]
		end
	end

	// single-byte opcodes: display, image, sleep, volume
	wire op_on   = op_strobe && (hbyte == lcd_cmd_pkg::OP_DISPLAY_ON);
	wire op_off  = op_strobe && (hbyte == lcd_cmd_pkg::OP_DISPLAY_OFF);
	wire op_slin = op_strobe && (hbyte == lcd_cmd_pkg::OP_SLEEP_ENTER);
	wire op_slou = op_strobe && (hbyte == lcd_cmd_pkg::OP_SLEEP_EXIT);
	wire op_vup  = op_strobe && (hbyte == lcd_cmd_pkg::OP_VOLUME_UP);
	wire op_vdn  = op_strobe && (hbyte == lcd_cmd_pkg::OP_VOLUME_DOWN);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			asleep_r  <= 1'b1;
			disp_on_r <= 1'b0;
			invert_r  <= 1'b0;
			volume_r  <= lcd_cmd_pkg::RST_VOLUME;
		end else begin
			if (op_slin) begin
				asleep_r  <= 1'b1; // [R12]
				disp_on_r <= 1'b0; // [R12]
			end else if (op_slou) begin
				asleep_r <= 1'b0; // [R13]
			end
			if (op_on && !asleep_r) begin
				disp_on_r <= 1'b1; // [R2] [R3]
			end else if (op_off) begin
				disp_on_r <= 1'b0; // [R4]
			end
			if (op_strobe && (hbyte == lcd_cmd_pkg::OP_INVERSE_IMAGE)) begin
				invert_r <= 1'b1; // [R5]
			end else if (op_strobe && (hbyte == lcd_cmd_pkg::OP_NORMAL_IMAGE)) begin
				invert_r <= 1'b0; // [R5]
			end
			// saturate rather than wrap so a stray step cannot jump the contrast
			if (op_vup && volume_r != lcd_cmd_pkg::VOLUME_MAX) begin
				volume_r <= volume_r + 6'h01; // [R19]
			end else if (op_vdn && volume_r != lcd_cmd_pkg::VOLUME_MIN) begin
				volume_r <= volume_r - 6'h01; // [R19]
			end
		end
	end

	// parameter capture; only defined bits are kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_r   <= lcd_cmd_pkg::RST_SCAN_ORDER;
			timing_r <= '{lcd_cmd_pkg::RST_CLOCK_DIV, lcd_cmd_pkg::RST_PATTERN,
				lcd_cmd_pkg::RST_DUTY, lcd_cmd_pkg::RST_INV_LINES};
			window_r <= '{8'h00, lcd_cmd_pkg::RST_WIN_END, 8'h00, lcd_cmd_pkg::RST_WIN_END};
			layout_r <= '{1'b0, 1'b0, 1'b0, lcd_cmd_pkg::RST_RGB_ORDER,
				lcd_cmd_pkg::RST_GRAY_MODE}; // [R23]
			pstash_r <= 8'h00;
		end else begin
			pstash_r <= take_par ? hbyte : pstash_r;
			if (p0 && op_is_scn) begin
				scan_r <= hbyte[2:0]; // [R6] [R20]
			end
			if (p0 && op_is_tim) begin
				timing_r.clock_div <= hbyte[3:2]; // [R8] [R20]
				timing_r.pattern   <= hbyte[1:0]; // [R9]
			end
			if (p1 && op_is_tim) begin
				timing_r.duty <= hbyte[5:0]; // [R10] [R20]
			end
			if (p2 && op_is_tim) begin
				// below two lines is not allowed, clamp to the shortest interval
				timing_r.inv_lines <= (hbyte[3:0] < lcd_cmd_pkg::INV_LINES_MIN) ?
					lcd_cmd_pkg::INV_LINES_MIN : hbyte[3:0]; // [R11]
			end
			// window pair takes effect only once both bytes arrived
			if (p1 && op_is_pg) begin
				window_r.page_start <= pstash_r; // [R14] [R16]
				window_r.page_end   <= hbyte;
			end
			if (p1 && op_is_cl) begin
				window_r.col_start <= pstash_r; // [R15] [R16]
				window_r.col_end   <= hbyte;
			end
			if (p0 && op_is_lay) begin
				layout_r.page_invert <= hbyte[0]; // [R17]
				layout_r.col_reverse <= hbyte[1];
				layout_r.page_dir    <= hbyte[2];
			end
			if (p1 && op_is_lay) begin
				layout_r.rgb_order <= hbyte[2:0]; // [R18]
			end
			if (p2 && op_is_lay) begin
				layout_r.gray_mode <= hbyte[2:0]; // [R22]
			end
		end
	end

	// memory write walk; inner axis chosen by the scan direction
	wire       data_byte = pm_strobe && in_write; // [R24]
	wire       pg_wrap, cl_wrap;
	wire [7:0] pg_val, cl_val;
	wire       pg_step   = data_byte && (layout_r.page_dir || cl_wrap);  // [R14] [R15]
	wire       cl_step   = data_byte && (!layout_r.page_dir || pg_wrap); // [R14] [R15]
	window_counter u_page (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (op_mw),
		.step    (pg_step),
		.start   (window_r.page_start),
		.stop    (window_r.page_end),
		.value   (pg_val),
		.wrap    (pg_wrap)
	);
	window_counter u_col (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (op_mw),
		.step    (cl_step),
		.start   (window_r.col_start),
		.stop    (window_r.col_end),
		.value   (cl_val),
		.wrap    (cl_wrap)
	);
	// inversion flags mirror the address seen by the ram
	wire [7:0] phys_page = layout_r.page_invert ? ~pg_val : pg_val; // [R17]
	wire [7:0] phys_col  = layout_r.col_reverse ? ~cl_val : cl_val; // [R17]

	// write strobe carries the address used before the step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			we_r     <= 1'b0;
			data_r   <= 8'h00;
			ram_page <= 8'h00;
			ram_col  <= 8'h00;
		end else begin
			we_r     <= data_byte; // [R24]
			data_r   <= data_byte ? hbyte : data_r;
			ram_page <= data_byte ? phys_page : ram_page;
			ram_col  <= data_byte ? phys_col : ram_col;
		end
	end

	// display timing: line clock, drive pattern, frame polarity
	wire [7:0] div_load =
		(timing_r.clock_div == 2'h0) ? lcd_cmd_pkg::DIV_LOAD_2 :
		(timing_r.clock_div == 2'h1) ? lcd_cmd_pkg::DIV_LOAD_4 :
		(timing_r.clock_div == 2'h2) ? lcd_cmd_pkg::DIV_LOAD_8 : lcd_cmd_pkg::DIV_LOAD_1; // [R8]
	wire [7:0] frame_lines = {timing_r.duty, 2'b11}; // [R10]
	wire [7:0] pat_load =
		(timing_r.pattern == 2'h0) ? lcd_cmd_pkg::PAT_LINES_8 :
		(timing_r.pattern == 2'h1) ? lcd_cmd_pkg::PAT_LINES_4 :
		(timing_r.pattern == 2'h2) ? lcd_cmd_pkg::PAT_LINES_16 : frame_lines; // [R9]
	wire       line_tick, pat_tick, fr_tick;
	divider_tick u_line (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (disp_on_r),
		.advance (1'b1),
		.load    (div_load),
		.tick    (line_tick)
	);
	divider_tick u_pattern (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (disp_on_r),
		.advance (line_tick),
		.load    (pat_load),
		.tick    (pat_tick)
	);
	divider_tick u_frame (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (disp_on_r),
		.advance (line_tick),
		.load    ({4'h0, timing_r.inv_lines}),
		.tick    (fr_tick)
	);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cl_r <= 1'b0;
			pa_r <= 1'b0;
			pb_r <= 1'b0;
			fr_r <= 1'b0;
		end else begin
			cl_r <= line_tick;                                       // [R2]
			pa_r <= !disp_on_r ? 1'b0 : (pat_tick ? !pa_r : pa_r);    // [R4]
			pb_r <= !disp_on_r ? 1'b0 : (pat_tick ? pa_r : !pa_r);    // [R9]
			fr_r <= !disp_on_r ? 1'b0 : (fr_tick ? !fr_r : fr_r);     // [R11]
		end
	end

	// apb response; unmapped addresses answer with slverr
	wire [31:0] rd_mux =
		hit_host ? {16'h0000, opcode_r, 3'h0, pidx_r} :
		hit_stat ? {24'h000000, state_r, invert_r, disp_on_r, asleep_r, 1'b0} :
		hit_tim  ? {18'h00000, timing_r} :
		hit_win  ? window_r :
		hit_addr ? {10'h000, volume_r, pg_val, cl_val} :
		hit_lay  ? {23'h000000, layout_r} : 32'h00000000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h00000000;
		end else begin
			pready_r  <= access;
			pslverr_r <= access && !mapped;
			prdata_r  <= (access && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

	// output flops; blanking and supply follow sleep and display state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_out_n     <= 1'b0;
			panel_blank_n   <= 1'b0;
			mid_drive_level <= 1'b1;
			supply_short    <= 1'b1;
		end else begin
			sleep_out_n     <= !asleep_r;               // [R12] [R13]
			panel_blank_n   <= disp_on_r && !asleep_r;  // [R4] [R12]
			mid_drive_level <= !disp_on_r;              // [R4]
			supply_short    <= asleep_r;                // [R12]
		end
	end

	assign prdata          = prdata_r;
	assign pready          = pready_r;
	assign pslverr         = pslverr_r;
	assign image_invert    = invert_r;
	assign line_clock      = cl_r;
	assign drive_pattern_a = pa_r;
	assign drive_pattern_b = pb_r;
	assign frame_polarity  = fr_r;
	assign scan_order      = scan_r;
	assign volume          = volume_r;
	assign ram_we          = we_r;
	assign ram_data        = data_r;
endmodule // lcd_command_decoder

//--- tb/lcd_cmd_asserts.sv
// output relations of the lcd command decoder
// assumes it is bound to the decoder; one clock domain
`timescale 1ns/1ps
module lcd_cmd_asserts (
	input wire logic       pclk,            // clock
	input wire logic       presetn,         // reset, low
	input wire logic       sleep_out_n,     // sleep pin
	input wire logic       panel_blank_n,   // blank pin
	input wire logic       mid_drive_level, // mid level
	input wire logic       supply_short,    // supply short
	input wire logic       line_clock,      // line clock
	input wire logic       drive_pattern_a, // pattern a
	input wire logic       drive_pattern_b, // pattern b
	input wire logic       frame_polarity,  // polarity
	input wire logic [5:0] volume,          // volume
	input wire logic       ram_we           // ram strobe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// display state pins
	off_blank_a: assert property (mid_drive_level |-> !panel_blank_n)
		else $error("blank pin high while display off");
	on_awake_a: assert property (panel_blank_n |-> sleep_out_n)
		else $error("display on while asleep");
	on_drive_a: assert property (panel_blank_n |-> !mid_drive_level)
		else $error("mid level while display on");
	asleep_pins_a: assert property (!sleep_out_n |-> supply_short && !panel_blank_n)
		else $error("sleep pins wrong");
	// volume moves one step at a time, so a skipped step shows here
	volume_step_a: assert property (!$stable(volume) |->
		volume == $past(volume) + 6'h01 || volume == $past(volume) - 6'h01)
		else $error("volume jumped");
	pattern_pair_a: assert property (panel_blank_n |-> drive_pattern_b != drive_pattern_a)
		else $error("pattern phases equal");
	// one cycle of slack: the pattern registers clear on the same edge that raises mid_drive_level
	off_quiet_a: assert property (mid_drive_level [*2] |-> !frame_polarity && !drive_pattern_b)
		else $error("drive signals active while off");
	write_pulse_a: assert property (ram_we |=> !ram_we)
		else $error("ram strobe too long");
	cover property (ram_we);
	cover property ($rose(panel_blank_n));
	cover property (line_clock && frame_polarity);
endmodule // lcd_cmd_asserts

bind lcd_command_decoder lcd_cmd_asserts lcd_cmd_asserts_i (.*);

//--- tb/apb_host_model.sv
// apb host model driving the decoder's register port
// assumes pclk from the bench; one transfer at a time
`timescale 1ns/1ps
module apb_host_model (
	input  wire logic        pclk,    // clock
	output logic             psel,    // select
	output logic             penable, // access phase
	output logic             pwrite,  // direction
	output logic      [7:0]  paddr,   // byte address
	output logic      [31:0] pwdata,  // write data
	input  wire logic [31:0] prdata,  // read data
	input  wire logic        pready,  // ready
	input  wire logic        pslverr, // error
	output logic             hung     // transfer never answered
);
	// idle bus at time zero
	initial begin
		{psel, penable, pwrite, hung} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// request held until pready is seen at an edge; bounded so a dead slave cannot hang
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'h0;
		if (n >= 64)
			hung <= 1'b1;
	endtask
endmodule // apb_host_model

//--- tb/tb_lcd_command_decoder.sv
// self-checking bench of the lcd command decoder
// assumes the host model and the bound checker
`timescale 1ns/1ps
module tb_lcd_command_decoder;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, hung, er;
	logic        sleep_out_n, panel_blank_n, mid_drive_level, image_invert, supply_short;
	logic        line_clock, drive_pattern_a, drive_pattern_b, frame_polarity, ram_we;
	logic [7:0]  paddr, ram_page, ram_col, ram_data, p;
	logic [31:0] pwdata, prdata, v;
	logic [31:0] seed = 32'h24;
	logic [2:0]  scan_order;
	logic [5:0]  volume;
	logic [7:0]  d [4];
	logic [23:0] wq [$];
	int          failures = 0;
	int          n_checks = 0;
	int          k;
	apb_host_model apb_host_model_i (.*);
	lcd_command_decoder lcd_command_decoder_i (.*);
	initial forever #12.5 pclk = ~pclk;
	// ram writes as seen at the ports
	always @(posedge pclk) if (ram_we === 1'b1) wq.push_back({ram_page, ram_col, ram_data});
	always @(posedge hung) begin
		failures++;
		report_and_stop();
	end
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	function automatic logic [31:0] tim_x(input logic [7:0] a, b, c);
		return {18'h0, a[3:0], b[5:0], (c[3:0] == 4'h0) ? lcd_cmd_pkg::INV_LINES_MIN : c[3:0]};
	endfunction
	function automatic logic [31:0] lay_x(input logic [7:0] a, b, c);
		return {23'h0, a[0], a[1], a[2], b[2:0], c[2:0]};
	endfunction
	// expected page and column of the i-th byte in a 2x2 window
	function automatic logic [23:0] wr_x(input int dir, i, input logic [7:0] x);
		return dir ? {8'(2 + i % 2), 8'(5 + i / 2), x} : {8'(2 + i / 2), 8'(5 + i % 2), x};
	endfunction
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		n_checks++;
		if (s !== x) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic chb(input string nm, input logic s, input logic x);
		chk(nm, {31'h0, s}, {31'h0, x});
	endtask
	// outputs lag an opcode by two cycles, so every byte is followed by three
	task automatic put(input logic t, input logic [7:0] b);
		apb_host_model_i.xfer(1'b1, lcd_cmd_pkg::ADDR_HOST_BYTE, {23'h0, t, b}, v, er);
		repeat (3) @(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a);
		apb_host_model_i.xfer(1'b0, a, 32'h0, v, er);
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(lcd_cmd_pkg::ADDR_TIMING);
		chk("timing", v, 32'h27A);
		rd(lcd_cmd_pkg::ADDR_WINDOW);
		chk("window", v, 32'h00FF00FF);
		rd(lcd_cmd_pkg::ADDR_LAYOUT);
		chk("layout", v, 32'h2);
		put(1'b0, lcd_cmd_pkg::OP_DISPLAY_ON);
		rd(lcd_cmd_pkg::ADDR_STATUS);
		chk("status", v, 32'h82);
		// every divider code, timing always set with the display off
		for (int c = 0; c < 4; c++) begin
			put(1'b0, lcd_cmd_pkg::OP_DISPLAY_OFF);
			put(1'b0, lcd_cmd_pkg::OP_DISP_TIMING);
			d[0] = rnd();
			d[0][3:2] = 2'(c);
			d[1] = rnd();
			d[2] = rnd();
			d[2][4] = 1'b1;
			for (int i = 0; i < 3; i++)
				put(1'b1, d[i]);
			put(1'b1, rnd());
			rd(lcd_cmd_pkg::ADDR_TIMING);
			chk("timing", v, tim_x(d[0], d[1], d[2]));
			put(1'b0, lcd_cmd_pkg::OP_SLEEP_EXIT);
			chb("blank", panel_blank_n, 1'b0);
			chb("sleep pin", sleep_out_n, 1'b1);
			put(1'b0, lcd_cmd_pkg::OP_DISPLAY_ON);
			chb("mid level", mid_drive_level, 1'b0);
			k = 0;
			repeat (64) begin
				@(posedge pclk);
				k += int'(line_clock === 1'b1);
			end
			chk("line clocks", k, 32'h80 >> (c == 3 ? 1 : c + 2));
		end
		put(1'b0, lcd_cmd_pkg::OP_INVERSE_IMAGE);
		chb("invert", image_invert, 1'b1);
		put(1'b0, lcd_cmd_pkg::OP_NORMAL_IMAGE);
		chb("invert", image_invert, 1'b0);
		for (int i = 0; i < 3; i++) begin
			p = rnd();
			put(1'b0, lcd_cmd_pkg::OP_COMMON_SCAN);
			put(1'b1, p);
			chk("scan", {29'h0, scan_order}, {29'h0, p[2:0]});
		end
		put(1'b0, lcd_cmd_pkg::OP_VOLUME_UP);
		chk("volume", {26'h0, volume}, 32'h21);
		put(1'b0, lcd_cmd_pkg::OP_VOLUME_DOWN);
		put(1'b0, lcd_cmd_pkg::OP_VOLUME_DOWN);
		chk("volume", {26'h0, volume}, 32'h1F);
		// both scan directions through a 2x2 window
		for (int dir = 0; dir < 2; dir++) begin
			p = rnd();
			p[2:0] = {1'(dir), 2'h0};
			d[1] = rnd();
			d[2] = rnd();
			d[2][2:0] = dir ? 3'h2 : 3'h1;
			put(1'b0, lcd_cmd_pkg::OP_DATA_LAYOUT);
			put(1'b1, p);
			put(1'b1, d[1]);
			put(1'b1, d[2]);
			rd(lcd_cmd_pkg::ADDR_LAYOUT);
			chk("layout", v, lay_x(p, d[1], d[2]));
			put(1'b0, lcd_cmd_pkg::OP_PAGE_WINDOW);
			put(1'b1, 8'h02);
			put(1'b1, 8'h03);
			put(1'b0, lcd_cmd_pkg::OP_COLUMN_WINDOW);
			put(1'b1, 8'h05);
			put(1'b1, 8'h06);
			rd(lcd_cmd_pkg::ADDR_WINDOW);
			chk("window", v, 32'h02030506);
			wq.delete();
			put(1'b0, lcd_cmd_pkg::OP_MEMORY_WRITE);
			for (int i = 0; i < 4; i++) begin
				d[i] = rnd();
				put(1'b1, d[i]);
			end
			put(1'b0, lcd_cmd_pkg::OP_NORMAL_IMAGE);
			put(1'b1, rnd());
			chk("writes", wq.size(), 32'h4);
			for (int i = 0; i < 4; i++)
				chk("write", {8'h0, wq[i]}, {8'h0, wr_x(dir, i, d[i])});
		end
		rd(8'h40);
		chb("unmapped err", er, 1'b1);
		chk("unmapped data", v, 32'h0);
		put(1'b0, lcd_cmd_pkg::OP_SLEEP_ENTER);
		chb("sleep pin", sleep_out_n, 1'b0);
		chb("supply", supply_short, 1'b1);
		chb("blank", panel_blank_n, 1'b0);
		chb("mid level", mid_drive_level, 1'b1);
		put(1'b0, lcd_cmd_pkg::OP_DISPLAY_ON);
		chb("blank", panel_blank_n, 1'b0);
		report_and_stop();
	end
endmodule // tb_lcd_command_decoder
